// file: tdt_level_unit.sv
`timescale 1ns/1ps
module tdt_level_unit #(
	parameter int SW = tdt_pkg::LVL_W
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Source samples and peak window
	input  wire logic signed [SW-1:0]    sample_i,
	input  wire logic                    restart_i,
	// Settings
	input  wire logic [1:0]              mode_i,
	input  wire logic signed [15:0]      manual_i,
	input  wire logic [15:0]             scale_i,
	// Resulting level
	output logic signed [15:0]           level_o
);
	import tdt_pkg::*;

	logic signed [SW-1:0] peak_hi_r;     // Positive peak in window
	logic signed [SW-1:0] peak_lo_r;     // Negative peak in window
	logic signed [SW:0]   mid;           // Half-way point between peaks
	logic signed [16:0]   req;           // Requested level before clamp
	logic [19:0]          lim;           // Twelve divisions of scale
	logic signed [20:0]   lim_s;         // Clamp bound, signed

	initial begin
		if (SW < 2 || SW > LVL_W) $error("tdt_level_unit: SW out of range");
	end

	// Peak tracking, reopened each window so the midpoint follows the signal
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peak_hi_r <= '0;
			peak_lo_r <= '0;
		end else if (restart_i) begin
			peak_hi_r <= sample_i;
			peak_lo_r <= sample_i;
		end else begin
			if (sample_i > peak_hi_r) peak_hi_r <= sample_i;
			if (sample_i < peak_lo_r) peak_lo_r <= sample_i;
		end
	end

	// Level source selection and clamp
	always_comb begin
		mid   = (SW+1)'((peak_hi_r + peak_lo_r) >>> 1);
		lim   = 20'(scale_i) * 20'(DIV_SPAN);
		lim_s = $signed({1'b0, lim});
		case (tdt_lvl_mode_type'(mode_i))
			LVL_TTL:  req = 17'(TTL_LEVEL_MV);
			LVL_ECL:  req = 17'(ECL_LEVEL_MV);
			LVL_HALF: req = 17'(mid);
			default:  req = 17'(manual_i);
		endcase
	end

	// Registered clamped level; small scales shrink the presets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_o <= '0;
		end else if (21'(req) > lim_s) begin
			level_o <= 16'(lim_s);
		end else if (21'(req) < -lim_s) begin
			level_o <= 16'(-lim_s);
		end else begin
			level_o <= 16'(req);
		end
	end
endmodule

// file: tdt_pkg.sv
package tdt_pkg;
	// Level and sample words are signed millivolts
	localparam int          LVL_W          = 16;
	localparam int          TMR_W          = 32;
	localparam int          N_SRC          = 5;
	// Preset levels and clamp span
	localparam logic signed [15:0] TTL_LEVEL_MV = 16'sd1400;
	localparam logic signed [15:0] ECL_LEVEL_MV = -16'sd1300;
	localparam logic [3:0]  DIV_SPAN       = 4'hc;
	localparam logic [15:0] HYST_MV        = 16'h0014;
	localparam logic [15:0] SCALE_RESET    = 16'h00c8;
	// Register byte addresses
	localparam logic [7:0]  ADR_CTRL       = 8'h00;
	localparam logic [7:0]  ADR_TIMEOUT    = 8'h04;
	localparam logic [7:0]  ADR_MAIN_LEVEL = 8'h08;
	localparam logic [7:0]  ADR_DLY_CTRL   = 8'h0c;
	localparam logic [7:0]  ADR_DLY_LEVEL  = 8'h10;
	localparam logic [7:0]  ADR_DLY_TIME   = 8'h14;
	localparam logic [7:0]  ADR_DLY_EVENTS = 8'h18;
	localparam logic [7:0]  ADR_SCALE      = 8'h1c;
	localparam logic [7:0]  ADR_POST_LEN   = 8'h20;
	localparam logic [7:0]  ADR_STATUS     = 8'h24;
	localparam logic [7:0]  ADR_LEVELS     = 8'h28;
	// Control register fields
	localparam int          CT_PSRC        = 0;
	localparam int          CT_POL         = 2;
	localparam int          CT_TYPE        = 4;
	localparam int          CT_CLASS       = 6;
	localparam int          CT_MAUX        = 9;
	localparam int          CT_MCOUP       = 10;
	localparam int          CT_MLMODE      = 12;
	// Delayed control register fields
	localparam int          DC_HMODE       = 0;
	localparam int          DC_SUB         = 1;
	localparam int          DC_DSRC        = 3;
	localparam int          DC_COUP        = 6;
	localparam int          DC_SLOPE       = 8;
	localparam int          DC_LMODE       = 9;
	localparam int          DC_SUBSEL      = 11;
	// Level register value field
	localparam int          LV_VAL         = 0;
	// Enumerations of settings
	typedef enum logic [1:0] {LVL_MANUAL, LVL_TTL, LVL_ECL, LVL_HALF} tdt_lvl_mode_type;
	typedef enum logic [1:0] {POL_HIGH, POL_LOW, POL_EITHER, POL_RSVD} tdt_pol_type;
	typedef enum logic [1:0] {TYP_EDGE, TYP_PULSE, TYP_LOGIC, TYP_RSVD} tdt_trig_type;
	typedef enum logic [2:0] {CLS_GLITCH, CLS_WIDTH, CLS_RUNT, CLS_SLEW, CLS_TIMEOUT,
		CLS_R5, CLS_R6, CLS_R7} tdt_class_type;
	typedef enum logic [1:0] {SUB_TIME, SUB_EVENTS, SUB_EV_TIME, SUB_RSVD} tdt_sub_type;
	typedef enum logic [1:0] {CP_DC, CP_NOISE, CP_FOLLOW, CP_RSVD} tdt_coup_type;
	localparam logic [2:0]  SRC_AUX        = 3'h4;
endpackage

// file: tdt_probe_model.sv
`timescale 1ns/1ps
module tdt_probe_model (
	// Commanded probe level
	input  wire logic               clk_i,
	input  wire logic signed [15:0] lvl_i,
	// Probed samples
	output logic signed [15:0]      ch_o [5]
);
	// Channels mirror the level so every source moves
	always_ff @(posedge clk_i) begin
		ch_o[0] <= lvl_i;
		ch_o[1] <= -lvl_i;
		ch_o[2] <= lvl_i >>> 1;
		ch_o[3] <= ~lvl_i;
		ch_o[4] <= lvl_i;
	end
endmodule

// file: tdt_trigger_core.sv
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
module tdt_trigger_core #(
	parameter int SW       = tdt_pkg::LVL_W,
	parameter int PEAK_WIN = 1000
) (
	// Clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// Classic Wishbone slave
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [7:0]                    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic [31:0]                        wb_dat_o,
	output logic                               wb_ack_o,
	// Probed inputs, asynchronous samples in millivolts
	input  wire logic signed [SW-1:0]          input_channel_one_i,
	input  wire logic signed [SW-1:0]          input_channel_two_i,
	input  wire logic signed [SW-1:0]          input_channel_three_i,
	input  wire logic signed [SW-1:0]          input_channel_four_i,
	input  wire logic signed [SW-1:0]          auxiliary_direct_input_i,
	// Acquisition side
	input  wire logic                          main_trig_i,
	input  wire logic                          main_record_end_i,
	output logic                               timeout_trig_o,
	output logic                               delayed_start_o,
	output logic                               delayed_trig_o,
	output logic                               capture_o,
	output logic                               pretrig_o,
	output logic                               record_done_o
);
	import tdt_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_RUN_DELAY, ST_WAIT_EVENTS, ST_WAIT_TIME,
		ST_ARMED, ST_CAPTURE} tdt_state_type;

	// Settings
	logic [1:0]             psrc_r;          // Pulse source channel
	logic [1:0]             pol_r;           // Timeout polarity
	logic [1:0]             mtype_r;         // Main trigger type
	logic [2:0]             mclass_r;        // Main pulse class
	logic                   maux_r;          // Main source is auxiliary
	logic [1:0]             mcoup_r;         // Main coupling
	logic [1:0]             mlmode_r;        // Main level mode
	logic signed [15:0]     mlevel_man_r;    // Main manual level
	logic [TMR_W-1:0]       timeout_r;       // Timeout in cycles
	logic                   hmode_r;         // 1: triggerable, 0: runs after
	logic [1:0]             sub_r;           // Delayed submode
	logic [2:0]             dsrc_r;          // Delayed source
	logic [1:0]             dcoup_r;         // Delayed coupling
	logic                   slope_r;         // 0 rising, 1 falling
	logic [1:0]             dlmode_r;        // Delayed level mode
	logic signed [15:0]     dlevel_man_r;    // Delayed manual level
	logic [TMR_W-1:0]       dtime_r;         // Delay time in cycles
	logic [TMR_W-1:0]       devents_r;       // Event count
	logic [15:0]            scale_r;         // Vertical scale, mV per division
	logic [15:0]            post_len_r;      // Posttrigger samples
	logic                   refused_r;       // Last triggerable request refused
	// Bus
	logic                   ack_r;           // Registered acknowledge
	logic [31:0]            rdat_r;          // Registered read data
	logic                   wr_en;           // Write strobe this cycle
	logic [31:0]            ctrl_wr;         // Control word, unselected lanes zero
	// Sampled inputs
	logic signed [SW-1:0]   src_s1 [N_SRC];  // First sync stage
	logic signed [SW-1:0]   src_s2 [N_SRC];  // Second sync stage, safe to use
	logic signed [SW-1:0]   pulse_smp;       // Pulse source sample
	logic signed [SW-1:0]   msrc_smp;        // Main level source sample
	logic signed [SW-1:0]   dsrc_smp;        // Delayed source sample
	logic signed [15:0]     pulse_w;         // Pulse sample widened
	logic signed [15:0]     dly_w;           // Delayed sample widened
	// Levels
	logic signed [15:0]     mlevel;          // Effective main level
	logic signed [15:0]     dlevel;          // Effective delayed level
	logic [15:0]            peak_cnt_r;      // Peak window counter
	logic                   peak_restart;    // Peak window reopen
	// Timeout
	logic                   side_r;          // Last side, 1 above level
	logic [TMR_W-1:0]       tout_cnt_r;      // Cycles since last crossing
	logic                   fired_r;         // Already fired for this stay
	logic                   above;           // Source above main level
	logic                   pol_ok;          // Side matches polarity
	logic                   tout_act;        // Timeout class active
	// Delayed trigger
	logic                   incompat;        // Main settings forbid triggerable
	logic                   dabove_r;        // Delayed comparator state
	logic                   dabove_nxt;      // Next comparator state
	logic signed [16:0]     hyst;            // Hysteresis from coupling
	logic [1:0]             dcoup_eff;       // Coupling after follow
	logic                   dedge;           // Selected slope crossing
	tdt_state_type          state_r;         // Sequencer state
	logic [TMR_W-1:0]       seq_cnt_r;       // Time or event counter
	logic                   main_evt;        // Main trigger event

	initial begin
		if (SW < 2 || SW > LVL_W) $error("tdt_trigger_core: SW out of range");
		if (PEAK_WIN < 2 || PEAK_WIN > 65535) $error("tdt_trigger_core: bad PEAK_WIN");
	end

	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// Two-stage synchronisers on the probed inputs
	always_ff @(posedge clk_i) begin
		src_s1[0] <= input_channel_one_i;
		src_s1[1] <= input_channel_two_i;
		src_s1[2] <= input_channel_three_i;
		src_s1[3] <= input_channel_four_i;
		src_s1[4] <= auxiliary_direct_input_i;
		src_s2    <= src_s1;
	end

	// Source selection; one pulse source serves every pulse class
	always_comb begin
		pulse_smp = src_s2[psrc_r];
		msrc_smp  = maux_r ? src_s2[SRC_AUX] : pulse_smp;
		dsrc_smp  = (dsrc_r >= SRC_AUX) ? src_s2[SRC_AUX] : src_s2[dsrc_r[1:0]];
		pulse_w   = 16'(pulse_smp);
		dly_w     = 16'(dsrc_smp);
	end

	// Peak window for the half-amplitude levels
	always_ff @(posedge clk_i) begin
		if (rst_i || peak_restart) peak_cnt_r <= '0;
		else peak_cnt_r <= peak_cnt_r + 16'h0001;
	end
	assign peak_restart = (peak_cnt_r == 16'(PEAK_WIN - 1));

	// Main and delayed level units
	tdt_level_unit #(.SW(SW)) u_main_level (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.sample_i  (msrc_smp),
		.restart_i (peak_restart),
		.mode_i    (mlmode_r),
		.manual_i  (mlevel_man_r),
		.scale_i   (scale_r),
		.level_o   (mlevel)
	);
	tdt_level_unit #(.SW(SW)) u_dly_level (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.sample_i  (dsrc_smp),
		.restart_i (peak_restart),
		.mode_i    (dlmode_r),
		.manual_i  (dlevel_man_r),
		.scale_i   (scale_r),
		.level_o   (dlevel)
	);

	// Main settings that cannot serve the triggerable timebase
	always_comb begin
		incompat = (tdt_trig_type'(mtype_r) == TYP_LOGIC)
			|| (tdt_trig_type'(mtype_r) == TYP_PULSE
			&& (tdt_class_type'(mclass_r) == CLS_RUNT
			|| tdt_class_type'(mclass_r) == CLS_SLEW))
			|| maux_r;
	end

	// Bus write strobe; one ack per request
	assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign ctrl_wr  = merge(32'h0, wb_dat_i, wb_sel_i);

	// Wishbone acknowledge and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end else begin
			ack_r  <= wb_cyc_i && wb_stb_i && !ack_r;
			rdat_r <= '0;
			case (wb_adr_i)
				ADR_CTRL: begin
					rdat_r[CT_PSRC +: 2]   <= psrc_r;
					rdat_r[CT_POL +: 2]    <= pol_r;
					rdat_r[CT_TYPE +: 2]   <= mtype_r;
					rdat_r[CT_CLASS +: 3]  <= mclass_r;
					rdat_r[CT_MAUX]        <= maux_r;
					rdat_r[CT_MCOUP +: 2]  <= mcoup_r;
					rdat_r[CT_MLMODE +: 2] <= mlmode_r;
				end
				ADR_TIMEOUT:    rdat_r <= timeout_r;
				ADR_MAIN_LEVEL: rdat_r[LV_VAL +: 16] <= mlevel_man_r;
				ADR_DLY_CTRL: begin
					rdat_r[DC_HMODE]      <= hmode_r;
					rdat_r[DC_SUB +: 2]   <= sub_r;
					rdat_r[DC_DSRC +: 3]  <= dsrc_r;
					rdat_r[DC_COUP +: 2]  <= dcoup_r;
					rdat_r[DC_SLOPE]      <= slope_r;
					rdat_r[DC_LMODE +: 2] <= dlmode_r;
				end
				ADR_DLY_LEVEL:  rdat_r[LV_VAL +: 16] <= dlevel_man_r;
				ADR_DLY_TIME:   rdat_r <= dtime_r;
				ADR_DLY_EVENTS: rdat_r <= devents_r;
				ADR_SCALE:      rdat_r[15:0] <= scale_r;
				ADR_POST_LEN:   rdat_r[15:0] <= post_len_r;
				ADR_STATUS:     rdat_r[8:0] <= {side_r, dabove_r, refused_r, incompat,
					hmode_r, 1'b0, 3'(state_r)};
				ADR_LEVELS:     rdat_r <= {dlevel, mlevel};
				default:        rdat_r <= '0;
			endcase
		end
	end

	// Main trigger settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{psrc_r, pol_r, mtype_r, mclass_r, maux_r, mcoup_r, mlmode_r} <= '0;
			timeout_r <= '0;
			scale_r   <= SCALE_RESET;
		end else if (wr_en) begin
			if (wb_adr_i == ADR_CTRL) begin
				psrc_r   <= ctrl_wr[CT_PSRC +: 2];
				pol_r    <= ctrl_wr[CT_POL +: 2];
				mtype_r  <= ctrl_wr[CT_TYPE +: 2];
				mclass_r <= ctrl_wr[CT_CLASS +: 3];
				maux_r   <= wb_sel_i[1] ? wb_dat_i[CT_MAUX] : maux_r;
				mcoup_r  <= ctrl_wr[CT_MCOUP +: 2];
				mlmode_r <= ctrl_wr[CT_MLMODE +: 2];
			end
			if (wb_adr_i == ADR_TIMEOUT) timeout_r <= merge(timeout_r, wb_dat_i, wb_sel_i);
			if (wb_adr_i == ADR_SCALE) scale_r <= 16'(merge({16'h0, scale_r}, wb_dat_i, wb_sel_i));
		end
	end

	// Manual levels; auxiliary on main with delayed source code SRC_AUX moves them together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mlevel_man_r <= '0;
			dlevel_man_r <= '0;
		end else if (wr_en) begin
			if (wb_adr_i == ADR_MAIN_LEVEL) begin
				mlevel_man_r <= 16'(merge(32'(mlevel_man_r), wb_dat_i, wb_sel_i));
				if (maux_r && dsrc_r == SRC_AUX)
					dlevel_man_r <= 16'(merge(32'(mlevel_man_r), wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == ADR_DLY_LEVEL) begin
				dlevel_man_r <= 16'(merge(32'(dlevel_man_r), wb_dat_i, wb_sel_i));
				if (maux_r && dsrc_r == SRC_AUX)
					mlevel_man_r <= 16'(merge(32'(dlevel_man_r), wb_dat_i, wb_sel_i));
			end
		end
	end

	// Delayed settings and horizontal delay mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{hmode_r, sub_r, dsrc_r, dcoup_r, slope_r, dlmode_r, refused_r} <= '0;
			dtime_r    <= '0;
			devents_r  <= '0;
			post_len_r <= '0;
		end else begin
			if (wr_en && wb_adr_i == ADR_DLY_CTRL) begin
				sub_r    <= wb_dat_i[DC_SUB +: 2];
				dsrc_r   <= wb_dat_i[DC_DSRC +: 3];
				dcoup_r  <= wb_dat_i[DC_COUP +: 2];
				slope_r  <= wb_dat_i[DC_SLOPE];
				dlmode_r <= wb_dat_i[DC_LMODE +: 2];
				if (wb_dat_i[DC_HMODE] || wb_dat_i[DC_SUBSEL]) begin
					hmode_r   <= !incompat;
					refused_r <= incompat;
				end else begin
					hmode_r   <= 1'b0;
					refused_r <= 1'b0;
				end
			end else if (incompat) begin
				hmode_r <= 1'b0;
			end
			if (wr_en && wb_adr_i == ADR_DLY_TIME) dtime_r <= merge(dtime_r, wb_dat_i, wb_sel_i);
			if (wr_en && wb_adr_i == ADR_DLY_EVENTS)
				devents_r <= merge(devents_r, wb_dat_i, wb_sel_i);
			if (wr_en && wb_adr_i == ADR_POST_LEN)
				post_len_r <= 16'(merge({16'h0, post_len_r}, wb_dat_i, wb_sel_i));
		end
	end

	// Timeout comparison against the main level
	always_comb begin
		above    = pulse_w > mlevel;
		tout_act = tdt_trig_type'(mtype_r) == TYP_PULSE
			&& tdt_class_type'(mclass_r) == CLS_TIMEOUT;
		case (tdt_pol_type'(pol_r))
			POL_HIGH:   pol_ok = side_r;
			POL_LOW:    pol_ok = !side_r;
			POL_EITHER: pol_ok = 1'b1;
			default:    pol_ok = 1'b0;
		endcase
	end

	// Timeout counter; fires once per uninterrupted stay on the polarity side longer than the limit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			side_r         <= 1'b0;
			tout_cnt_r     <= '0;
			fired_r        <= 1'b0;
			timeout_trig_o <= 1'b0;
		end else begin
			side_r         <= above;
			timeout_trig_o <= 1'b0;
			if (above != side_r || !tout_act) begin
				tout_cnt_r <= '0;
				fired_r    <= 1'b0;
			end else begin
				if (tout_cnt_r != '1) tout_cnt_r <= tout_cnt_r + 1'b1;
				if (tout_cnt_r >= timeout_r && !fired_r && pol_ok) begin
					timeout_trig_o <= 1'b1;
					fired_r        <= 1'b1;
				end
			end
		end
	end

	// Delayed comparator with coupling-dependent hysteresis
	always_comb begin
		dcoup_eff = (tdt_coup_type'(dcoup_r) == CP_FOLLOW) ? mcoup_r : dcoup_r;
		hyst      = (tdt_coup_type'(dcoup_eff) == CP_NOISE) ? 17'(HYST_MV) : '0;
		if (17'(dly_w) > 17'(dlevel) + hyst) dabove_nxt = 1'b1;
		else if (17'(dly_w) < 17'(dlevel) - hyst) dabove_nxt = 1'b0;
		else dabove_nxt = dabove_r;
		dedge = slope_r ? (dabove_r && !dabove_nxt) : (!dabove_r && dabove_nxt);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) dabove_r <= 1'b0;
		else dabove_r <= dabove_nxt;
	end

	assign main_evt = main_trig_i || timeout_trig_o;

	// Delay sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r         <= ST_IDLE;
			seq_cnt_r       <= '0;
			delayed_start_o <= 1'b0;
			delayed_trig_o  <= 1'b0;
			record_done_o   <= 1'b0;
		end else begin
			delayed_start_o <= 1'b0;
			delayed_trig_o  <= 1'b0;
			record_done_o   <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					seq_cnt_r <= '0;
					if (main_evt) begin
						if (!hmode_r || incompat) state_r <= ST_RUN_DELAY;
						else if (tdt_sub_type'(sub_r) == SUB_TIME) state_r <= ST_WAIT_TIME;
						else state_r <= ST_WAIT_EVENTS;
					end
				end
				ST_RUN_DELAY: begin
					if (seq_cnt_r >= dtime_r) begin
						state_r         <= ST_CAPTURE;
						seq_cnt_r       <= '0;
						delayed_start_o <= 1'b1;
					end else seq_cnt_r <= seq_cnt_r + 1'b1;
				end
				ST_WAIT_EVENTS: begin
					if (main_record_end_i) state_r <= ST_IDLE;
					else if (seq_cnt_r >= devents_r) begin
						seq_cnt_r <= '0;
						state_r   <= (tdt_sub_type'(sub_r) == SUB_EV_TIME)
							? ST_WAIT_TIME : ST_ARMED;
					end else if (dedge) seq_cnt_r <= seq_cnt_r + 1'b1;
				end
				ST_WAIT_TIME: begin
					if (main_record_end_i) state_r <= ST_IDLE;
					else if (seq_cnt_r >= dtime_r) begin
						seq_cnt_r <= '0;
						state_r   <= ST_ARMED;
					end else seq_cnt_r <= seq_cnt_r + 1'b1;
				end
				ST_ARMED: begin
					if (dedge) begin
						state_r         <= ST_CAPTURE;
						delayed_trig_o  <= 1'b1;
						delayed_start_o <= 1'b1;
					end else if (main_record_end_i) state_r <= ST_IDLE;
				end
				ST_CAPTURE: begin
					if (seq_cnt_r + 1'b1 >= TMR_W'(post_len_r)) begin
						state_r       <= ST_IDLE;
						seq_cnt_r     <= '0;
						record_done_o <= 1'b1;
					end else seq_cnt_r <= seq_cnt_r + 1'b1;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Pretrigger sampling runs whenever posttrigger capture is not
	assign capture_o = (state_r == ST_CAPTURE);
	assign pretrig_o = !capture_o;
endmodule

// file: tdt_trigger_core_bench.sv
`timescale 1ns/1ps
module tdt_trigger_core_bench;
	import tdt_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mt = 0, rend = 0, tto, dst, cap;
	logic ack, dtr, pre, done;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, q, rd;
	logic signed [15:0] lvl = 16'sh0;
	logic signed [15:0] ch [5];
	logic [31:0] bad [4] = '{32'h200, 32'h20, 32'h90, 32'hd0};
	int n_mismatch = 0, n_compared = 0, k, t, s, d, p;
	always #5 clk_i = ~clk_i;
	tdt_probe_model u_prb (.clk_i(clk_i), .lvl_i(lvl), .ch_o(ch));
	tdt_trigger_core #(.PEAK_WIN(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rd), .wb_ack_o(ack), .input_channel_one_i(ch[0]), .input_channel_two_i(ch[1]),
		.input_channel_three_i(ch[2]), .input_channel_four_i(ch[3]),
		.auxiliary_direct_input_i(ch[4]), .main_trig_i(mt), .main_record_end_i(rend),
		.timeout_trig_o(tto), .delayed_start_o(dst), .delayed_trig_o(dtr), .capture_o(cap),
		.pretrig_o(pre), .record_done_o(done));
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH value exp %h got %h", e, g);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		// A bus that never answers fails the run
		if (t >= 50) n_mismatch++;
		q = rd;
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic close_out;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		close_out;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, ADR_SCALE, 0); cmp({16'h0, SCALE_RESET}, q);
		bus(0, 8'h3c, 0); cmp(32'h0, q);
		bus(1, ADR_TIMEOUT, 32'h3);
		// High, low, either: cross, then stay past the limit
		for (k = 0; k < 3; k++) begin
			lvl <= (k == 1) ? 16'sh1f4 : -16'sh1f4;
			bus(1, ADR_CTRL, 32'h110 | (k << 2));
			lvl <= -lvl;
			t = 0;
			do begin
				@(posedge clk_i);
				t++;
			end while (tto !== 1'b1 && t < 40);
			cmp(1, t > 3 && t < 20);
		end
		// Stays shorter than the limit never fire
		bus(1, ADR_TIMEOUT, 32'h8);
		s = 0;
		for (k = 0; k < 40; k++) begin
			@(posedge clk_i);
			if (k % 4 == 0) lvl <= -lvl;
			s += (tto === 1'b1);
		end
		cmp(0, s);
		bus(1, ADR_CTRL, 0);
		bus(1, ADR_DLY_TIME, 5);
		bus(1, ADR_POST_LEN, 4);
		bus(1, ADR_DLY_CTRL, 0);
		repeat (30) @(posedge clk_i);
		mt <= 1'b1;
		@(posedge clk_i);
		mt <= 1'b0;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (dst !== 1'b1 && t < 40);
		// Start seen delay plus two edges after the main trigger edge
		cmp(5 + 2, t);
		// Capture already stands at the edge where start is seen
		s = (cap === 1'b1);
		p = (pre === 1'b0);
		d = 0;
		repeat (20) @(posedge clk_i) begin
			s += (cap === 1'b1);
			p += (pre === 1'b0);
			d += (done === 1'b1);
		end
		cmp(4, s);
		cmp(4, p);
		cmp(1, d);
		for (k = 0; k < 4; k++) begin
			bus(1, ADR_CTRL, bad[k]);
			bus(1, ADR_DLY_CTRL, 1);
			bus(0, ADR_STATUS, 0); cmp(32'h40, q & 32'h50);
		end
		bus(1, ADR_CTRL, 0);
		bus(1, ADR_DLY_CTRL, 32'h802);
		bus(0, ADR_STATUS, 0); cmp(32'h10, q & 32'h10);
		bus(1, ADR_DLY_CTRL, 32'h200);
		bus(0, ADR_LEVELS, 0); cmp(TTL_LEVEL_MV, q[31:16]);
		bus(1, ADR_DLY_CTRL, 32'h400);
		bus(0, ADR_LEVELS, 0); cmp({16'h0, ECL_LEVEL_MV}, q[31:16]);
		bus(1, ADR_SCALE, 32'h64);
		bus(1, ADR_DLY_CTRL, 32'h200);
		bus(0, ADR_LEVELS, 0); cmp(DIV_SPAN * 16'h64, q[31:16]);
		// Triggerable after time on channel one, rising slope, level zero
		lvl <= -16'sh1f4;
		bus(1, ADR_DLY_CTRL, 32'h1);
		bus(0, ADR_STATUS, 0); cmp(32'h10, q & 32'h50);
		mt <= 1'b1;
		@(posedge clk_i);
		mt <= 1'b0;
		s = 0;
		repeat (20) @(posedge clk_i) s += (dtr === 1'b1);
		cmp(0, s);
		lvl <= 16'sh1f4;
		repeat (20) @(posedge clk_i) s += (dtr === 1'b1);
		cmp(1, s);
		// Record end abandons an armed sequence
		lvl <= -16'sh1f4;
		repeat (10) @(posedge clk_i);
		mt <= 1'b1;
		@(posedge clk_i);
		mt <= 1'b0;
		repeat (20) @(posedge clk_i);
		rend <= 1'b1;
		@(posedge clk_i);
		rend <= 1'b0;
		lvl <= 16'sh1f4;
		s = 0;
		repeat (20) @(posedge clk_i) s += (dtr === 1'b1);
		cmp(0, s);
		close_out;
	end
endmodule

// file: tdt_trigger_core_chk.sv
`timescale 1ns/1ps
module tdt_trigger_core_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic timeout_trig_o,
	input wire logic delayed_start_o,
	input wire logic delayed_trig_o,
	input wire logic capture_o,
	input wire logic pretrig_o,
	input wire logic record_done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_due: assert property (p_ack_due) else $error("ack missing");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_pre; pretrig_o != capture_o; endproperty
	a_pre: assert property (p_pre) else $error("pretrig wrong");
	property p_tmo; timeout_trig_o |=> !timeout_trig_o; endproperty
	a_tmo: assert property (p_tmo) else $error("timeout pulse long");
	property p_dst; delayed_start_o |=> !delayed_start_o; endproperty
	a_dst: assert property (p_dst) else $error("start pulse long");
	property p_dtr; delayed_trig_o |=> !delayed_trig_o; endproperty
	a_dtr: assert property (p_dtr) else $error("delayed pulse long");
	property p_done; record_done_o |=> !record_done_o; endproperty
	a_done: assert property (p_done) else $error("done pulse long");
	property p_cap; $rose(capture_o) |-> delayed_start_o; endproperty
	a_cap: assert property (p_cap) else $error("capture began without start");
endmodule
bind tdt_trigger_core tdt_trigger_core_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.timeout_trig_o(timeout_trig_o), .delayed_start_o(delayed_start_o),
	.delayed_trig_o(delayed_trig_o), .capture_o(capture_o), .pretrig_o(pretrig_o),
	.record_done_o(record_done_o));
